// >>> hw/smp_consts.vh
// Constants shared by the dual-port memory and its testbench.
// Assumes inclusion by bare name from files under hw/.
`ifndef SMP_CONSTS_VH
`define SMP_CONSTS_VH
// Array shape: 8K words of nine bits
`define SMP_AW          13
`define SMP_DW          9
`define SMP_DEPTH       8192
`define SMP_NPORT       2
// Register word offsets (byte addresses)
`define SMP_REG_CTRL    8'h00
`define SMP_REG_STATUS  8'h04
`define SMP_REG_CNT0    8'h08
`define SMP_REG_CNT1    8'h0C
// Field positions
`define SMP_CTRL_DIS_LSB 0
`define SMP_STAT_SBY_LSB 0
// Reset values
`define SMP_RST_CTRL    2'h0
// Bus answers
`define SMP_RESP_OKAY   2'h0
`define SMP_RESP_SLVERR 2'h2
`endif

// >>> hw/smp_port.v
// One memory port: pin synchroniser, input registers, burst counter,
// write pulse and flow-through or pipelined read path.
// Assumes the array read is combinational on mem_addr_q.
`timescale 1ns/1ps
`default_nettype none
module smp_port #(
    parameter AW = 13,
    parameter DW = 9
) (
    input  wire          aclk,
    input  wire          aresetn,
    input  wire          clk_en,
    input  wire          port_clk,
    input  wire [AW-1:0] addr,
    input  wire          address_strobe_n,
    input  wire          count_advance_n,
    input  wire          counter_clear_n,
    input  wire          select_active_low_n,
    input  wire          select_active_high,
    input  wire          rw_n,
    input  wire          oe_n,
    input  wire          latency_select,
    input  wire [DW-1:0] data_i,
    input  wire          force_desel,
    input  wire [DW-1:0] mem_rdata,
    output reg  [AW-1:0] mem_addr_q,
    output reg           mem_we_q,
    output reg  [DW-1:0] mem_wdata_q,
    output reg  [DW-1:0] data_o_q,
    output reg           data_oe_q,
    output reg           standby_q,
    output reg  [AW-1:0] count_q
);
    localparam SW = AW + DW + 9;
    // -----------------------------------------------
    // Pin synchroniser
    // -----------------------------------------------
    wire [SW-1:0] pins = {port_clk, addr, address_strobe_n, count_advance_n,
                          counter_clear_n, select_active_low_n, select_active_high,
                          rw_n, oe_n, latency_select, data_i};
    reg  [SW-1:0] meta_q;       // First stage, read by sync_q only
    reg  [SW-1:0] sync_q;       // Second stage
    reg           clk_prev_q;   // Last synced port clock
    wire          s_clk   = sync_q[SW-1];
    wire [AW-1:0] s_addr  = sync_q[SW-2 -: AW];
    wire          s_ads_n = sync_q[DW+7];
    wire          s_cnt_n = sync_q[DW+6];
    wire          s_clr_n = sync_q[DW+5];
    wire          s_cs0_n = sync_q[DW+4];
    wire          s_cs1   = sync_q[DW+3];
    wire          s_rw_n  = sync_q[DW+2];
    wire          s_oe_n  = sync_q[DW+1];
    wire          s_lat   = sync_q[DW];
    wire [DW-1:0] s_din   = sync_q[DW-1:0];
    wire          p_edge  = s_clk & ~clk_prev_q;   // Port clock rising edge
    // Both selects active and not blocked by software
    wire          sel     = ~s_cs0_n & s_cs1 & ~force_desel;
    // -----------------------------------------------
    // Burst counter next value
    // -----------------------------------------------
    reg  [AW-1:0] cnt_d;
    always @* begin
        if (!s_clr_n) begin
            cnt_d = {AW{1'b0}};
        end else if (!s_ads_n) begin
            cnt_d = s_addr;
        end else if (!s_cnt_n) begin
            cnt_d = count_q + {{(AW-1){1'b0}}, 1'b1};
        end else begin
            cnt_d = count_q;
        end
    end
    // -----------------------------------------------
    // Port registers and read path
    // -----------------------------------------------
    reg           rd_cap_q;     // Array output valid this cycle
    reg           flow_act_q;   // Read accepted at last edge
    reg           pipe_act_q;   // Read one edge older
    reg  [DW-1:0] flow_data_q;  // Unregistered-path data
    reg  [DW-1:0] pipe_data_q;  // Output register
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_q      <= {SW{1'b0}};
            sync_q      <= {SW{1'b0}};
            clk_prev_q  <= 1'b0;
            count_q     <= {AW{1'b0}};
            mem_addr_q  <= {AW{1'b0}};
            mem_we_q    <= 1'b0;
            mem_wdata_q <= {DW{1'b0}};
            rd_cap_q    <= 1'b0;
            flow_act_q  <= 1'b0;
            pipe_act_q  <= 1'b0;
            flow_data_q <= {DW{1'b0}};
            pipe_data_q <= {DW{1'b0}};
            data_o_q    <= {DW{1'b0}};
            data_oe_q   <= 1'b0;
            standby_q   <= 1'b1;
        end else if (clk_en) begin
            meta_q     <= pins;
            sync_q     <= meta_q;
            clk_prev_q <= s_clk;
            mem_we_q   <= 1'b0;     // One-cycle self-timed pulse
            rd_cap_q   <= p_edge;
            if (p_edge) begin       // Address, counter control, rw_n, select and data inputs taken at the edge; oe_n and latency_select act every cycle
                count_q     <= cnt_d;   // Counter ignores selects
                mem_addr_q  <= cnt_d;
                mem_we_q    <= sel & ~s_rw_n;
                mem_wdata_q <= s_din;
                standby_q   <= ~sel;
                flow_act_q  <= sel & s_rw_n;
                pipe_act_q  <= flow_act_q;
                pipe_data_q <= flow_data_q;
            end
            if (rd_cap_q) begin
                flow_data_q <= mem_rdata;
            end
            // Pipelined mode shows data one port cycle later
            data_o_q  <= s_lat ? pipe_data_q : flow_data_q;
            data_oe_q <= ~s_oe_n & (s_lat ? pipe_act_q : flow_act_q);
        end
    end
endmodule
`default_nettype wire

// >>> hw/smp_dpram.v
// Dual-port 8K x 9 synchronous memory with burst counters and an
// AXI4-Lite register slave for port control and counter status.
// Assumes aclk is the only clock; port clocks arrive as pins.
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "smp_consts.vh"
module smp_dpram #(
    parameter AW    = `SMP_AW,
    parameter DW    = `SMP_DW,
    parameter DEPTH = `SMP_DEPTH,
    parameter NP    = `SMP_NPORT,
    parameter XAW   = 8
) (
    input  wire             aclk,
    input  wire             aresetn,
    input  wire             clk_en,
    // -----------------------------------------------
    // AXI4-Lite register slave
    // -----------------------------------------------
    input  wire [XAW-1:0]   s_axi_awaddr,
    input  wire             s_axi_awvalid,
    output reg              s_axi_awready,
    input  wire [31:0]      s_axi_wdata,
    input  wire [3:0]       s_axi_wstrb,
    input  wire             s_axi_wvalid,
    output reg              s_axi_wready,
    output reg  [1:0]       s_axi_bresp,
    output reg              s_axi_bvalid,
    input  wire             s_axi_bready,
    input  wire [XAW-1:0]   s_axi_araddr,
    input  wire             s_axi_arvalid,
    output reg              s_axi_arready,
    output reg  [31:0]      s_axi_rdata,
    output reg  [1:0]       s_axi_rresp,
    output reg              s_axi_rvalid,
    input  wire             s_axi_rready,
    // -----------------------------------------------
    // Memory port pins, port 0 in the low slice
    // -----------------------------------------------
    input  wire [NP-1:0]    port_clk,
    input  wire [NP*AW-1:0] addr,
    input  wire [NP-1:0]    address_strobe_n,
    input  wire [NP-1:0]    count_advance_n,
    input  wire [NP-1:0]    counter_clear_n,
    input  wire [NP-1:0]    select_active_low_n,
    input  wire [NP-1:0]    select_active_high,
    input  wire [NP-1:0]    rw_n,
    input  wire [NP-1:0]    oe_n,
    input  wire [NP-1:0]    latency_select,
    input  wire [NP*DW-1:0] data_i,
    output wire [NP*DW-1:0] data_o,
    output wire [NP-1:0]    data_oe,
    output wire [NP-1:0]    standby
);
    // -----------------------------------------------
    // Shared storage
    // -----------------------------------------------
    // Flip-flop array, one word per address
    reg  [DW-1:0]    mem_q [0:DEPTH-1];
    // Per-port access address
    wire [NP*AW-1:0] mem_addr;
    // Per-port write strobe
    wire [NP-1:0]    mem_we;
    // Per-port write data
    wire [NP*DW-1:0] mem_wdata;
    // Per-port read data
    wire [NP*DW-1:0] mem_rdata;
    // Per-port burst counter value
    wire [NP*AW-1:0] count;
    // Software port block bits
    reg  [NP-1:0]    ctrl_q;
    // Loop index for the write process
    integer          i;

    // Array write, each port independently
    // Equal addresses in one cycle: last port wins, unspecified
    always @(posedge aclk) begin
        if (clk_en) begin
            for (i = 0; i < NP; i = i + 1) begin
                if (mem_we[i]) begin
                    mem_q[mem_addr[i*AW +: AW]] <= mem_wdata[i*DW +: DW];
                end
            end
        end
    end

    // -----------------------------------------------
    // Port instances
    // -----------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NP; g = g + 1) begin : gen_port
            // Combinational read, no wait between ports
            assign mem_rdata[g*DW +: DW] = mem_q[mem_addr[g*AW +: AW]];

            // Own counter and pipeline per port
            smp_port #(
                .AW (AW),
                .DW (DW)
            ) u_port (
                .aclk                (aclk),
                .aresetn             (aresetn),
                .clk_en              (clk_en),
                .port_clk            (port_clk[g]),
                .addr                (addr[g*AW +: AW]),
                .address_strobe_n    (address_strobe_n[g]),
                .count_advance_n     (count_advance_n[g]),
                .counter_clear_n     (counter_clear_n[g]),
                .select_active_low_n (select_active_low_n[g]),
                .select_active_high  (select_active_high[g]),
                .rw_n                (rw_n[g]),
                .oe_n                (oe_n[g]),
                .latency_select      (latency_select[g]),
                .data_i              (data_i[g*DW +: DW]),
                .force_desel         (ctrl_q[g]),
                .mem_rdata           (mem_rdata[g*DW +: DW]),
                .mem_addr_q          (mem_addr[g*AW +: AW]),
                .mem_we_q            (mem_we[g]),
                .mem_wdata_q         (mem_wdata[g*DW +: DW]),
                .data_o_q            (data_o[g*DW +: DW]),
                .data_oe_q           (data_oe[g]),
                .standby_q           (standby[g]),
                .count_q             (count[g*AW +: AW])
            );
        end
    endgenerate

    // -----------------------------------------------
    // Register write channel
    // -----------------------------------------------
    // Address taken, waiting for data
    reg              aw_got_q;
    // Latched write address
    reg  [XAW-1:0]   aw_addr_q;
    // Data taken, waiting for address
    reg              w_got_q;
    // Latched write data
    reg  [31:0]      w_data_q;
    // Latched byte strobes
    reg  [3:0]       w_strb_q;
    // Both halves present, response free
    wire             wr_go = aw_got_q & w_got_q & ~s_axi_bvalid;
    // Decoded write target is the control word
    wire             wr_ctrl = (aw_addr_q == `SMP_REG_CTRL);
    // Write target is any mapped word
    wire             wr_hit = wr_ctrl
                            | (aw_addr_q == `SMP_REG_STATUS)
                            | (aw_addr_q == `SMP_REG_CNT0)
                            | (aw_addr_q == `SMP_REG_CNT1);

    // Address and data in either order, answer after both
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SMP_RESP_OKAY;
            aw_got_q      <= 1'b0;
            aw_addr_q     <= {XAW{1'b0}};
            w_got_q       <= 1'b0;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            ctrl_q        <= `SMP_RST_CTRL;
        end else if (clk_en) begin
            // Address handshake
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q      <= 1'b1;
                aw_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!aw_got_q && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            // Data handshake
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q      <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (!w_got_q && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            // Commit and respond
            if (wr_go) begin
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `SMP_RESP_OKAY : `SMP_RESP_SLVERR;
                if (wr_ctrl && w_strb_q[0]) begin
                    ctrl_q <= w_data_q[`SMP_CTRL_DIS_LSB +: NP];
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // -----------------------------------------------
    // Register read channel
    // -----------------------------------------------
    // Read word for the presented address
    reg  [31:0]      rd_word;
    // Address matched a register
    reg              rd_hit;

    // Read decode, unused bits zero
    always @* begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            `SMP_REG_CTRL: begin
                rd_word[`SMP_CTRL_DIS_LSB +: NP] = ctrl_q;
            end
            `SMP_REG_STATUS: begin
                rd_word[`SMP_STAT_SBY_LSB +: NP] = standby;
            end
            `SMP_REG_CNT0: begin
                rd_word[AW-1:0] = count[0 +: AW];
            end
            `SMP_REG_CNT1: begin
                rd_word[AW-1:0] = count[AW +: AW];
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // One read at a time, answer the cycle after the address
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `SMP_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= rd_hit ? `SMP_RESP_OKAY : `SMP_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// >>> verif/smp_dpram_monitor.sv
// Checker on the memory top level: select, output and bus timing.
// Assumes port pins are stable around each port clock rise.
`timescale 1ns/1ps
`default_nettype none
module smp_dpram_monitor #(
    parameter DW = 9,
    parameter NP = 2
) (
    input wire logic             aclk,
    input wire logic             aresetn,
    input wire logic             s_axi_awvalid,
    input wire logic             s_axi_awready,
    input wire logic             s_axi_wvalid,
    input wire logic             s_axi_wready,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic             s_axi_rvalid,
    input wire logic [NP-1:0]    port_clk,
    input wire logic [NP-1:0]    select_active_low_n,
    input wire logic [NP-1:0]    select_active_high,
    input wire logic [NP-1:0]    rw_n,
    input wire logic [NP-1:0]    oe_n,
    input wire logic [NP-1:0]    latency_select,
    input wire logic [NP*DW-1:0] data_o,
    input wire logic [NP-1:0]    data_oe,
    input wire logic [NP-1:0]    standby
);
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------------------------------------
    // Age since port 0 clock rise or enable change
    // ----------------------------------------
    logic [3:0] since_q;  // Saturating age
    logic       pclk_q;   // Port clock last cycle
    logic       oe_q;     // Enable last cycle
    always @(posedge aclk) begin
        pclk_q <= port_clk[0];
        oe_q   <= oe_n[0];
        if (!aresetn || (port_clk[0] && !pclk_q) || (oe_n[0] != oe_q)) begin
            since_q <= 4'h0;
        end else if (since_q != 4'hf) begin
            since_q <= since_q + 4'h1;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    desel_stby_a : assert property (
        $rose(port_clk[0]) && (select_active_low_n[0] || !select_active_high[0]) |-> ##[1:6] standby[0])
        else $error("port 0 not in standby after deselect");
    desel_stby1_a : assert property (
        $rose(port_clk[1]) && (select_active_low_n[1] || !select_active_high[1]) |-> ##[1:6] standby[1])
        else $error("port 1 not in standby after deselect");
    standby_quiet_a : assert property (
        (standby[0] && !latency_select[0]) [*8] |-> !data_oe[0])
        else $error("port 0 drives in standby");
    oe_off_a : assert property (
        $rose(oe_n[0]) |-> ##[1:4] !data_oe[0])
        else $error("port 0 drive not released");
    data_edge_a : assert property (
        $changed(data_o[DW-1:0]) |-> since_q <= 4'h7)
        else $error("port 0 data changed off an edge");
    write_quiet_a : assert property (
        $rose(port_clk[0]) && !rw_n[0] |-> ##[1:6] !data_oe[0])
        else $error("port 0 drives on a write");
    rd_answer_a : assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    wr_answer_a : assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    aw_once_a : assert property (
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("awready stayed high");
endmodule
bind smp_dpram smp_dpram_monitor #(.DW(DW), .NP(NP)) mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .port_clk,
    .select_active_low_n, .select_active_high, .rw_n, .oe_n, .latency_select, .data_o, .data_oe, .standby);
`default_nettype wire

// >>> verif/smp_host_model.sv
// Host model of one memory port: pins and a gated port clock.
// Assumes aclk is the bench clock; pins move only after its rising edge.
`timescale 1ns/1ps
`default_nettype none
module smp_host_model (
    input  wire logic        aclk,
    output var  logic        port_clk,
    output var  logic [12:0] addr,
    output var  logic        address_strobe_n,
    output var  logic        count_advance_n,
    output var  logic        counter_clear_n,
    output var  logic        select_active_low_n,
    output var  logic        select_active_high,
    output var  logic        rw_n,
    output var  logic        oe_n,
    output var  logic        latency_select,
    output var  logic [8:0]  data_i
);
    // Idle pins: clock low, deselected, reading
    initial begin
        {port_clk, address_strobe_n, count_advance_n, counter_clear_n} = 4'h7;
        {select_active_low_n, select_active_high, rw_n, oe_n, latency_select} = 5'h1c;
        {addr, data_i} = 22'h00_0000;
    end
    // Mode pins: read latency and output enable
    task automatic set_mode(input logic lat, input logic oen);
        @(posedge aclk);
        latency_select <= lat;
        oe_n <= oen;
    endtask
    // One port cycle; ctl is strobe, advance, clear, low select, high select
    task automatic cyc(input logic rw, input logic [12:0] a, input logic [8:0] d, input logic [4:0] ctl);
        @(posedge aclk);
        rw_n <= rw;
        addr <= a;
        data_i <= rw ? ~data_i : d; // Released bus shows the inverse
        {address_strobe_n, count_advance_n, counter_clear_n} <= ctl[4:2];
        {select_active_low_n, select_active_high} <= ctl[1:0];
        repeat (4) @(posedge aclk);
        port_clk <= 1'b1;
        repeat (6) @(posedge aclk);
        port_clk <= 1'b0;
        repeat (6) @(posedge aclk);
    endtask
endmodule
`default_nettype wire

// >>> verif/smp_dpram_tb_top.sv
// Bench for the dual-port memory: register bus tasks and port cycles.
// Assumes smp_consts.vh is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "smp_consts.vh"
module smp_dpram_tb_top;
    logic              aclk = 1'b0;
    logic              aresetn = 1'b0;
    logic [7:0]        s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0]       s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    wire  logic [1:0]  port_clk, address_strobe_n, count_advance_n, counter_clear_n, select_active_low_n;
    wire  logic [1:0]  select_active_high, rw_n, oe_n, latency_select, data_oe, standby;
    wire  logic [25:0] addr;
    wire  logic [17:0] data_i, data_o;
    int                fails = 0;
    int                tests_run = 0;
    // Port controls: strobe, advance, clear, low select, high select
    localparam logic [4:0] LOAD = 5'b0_1101, ADV = 5'b1_0101, HOLD = 5'b1_1101;
    localparam logic [4:0] ALL = 5'b0_0001, BOTH = 5'b0_0101, DADV = 5'b1_0110, DES = 5'b0_1110;
    always #12.5 aclk = ~aclk;
    smp_dpram uut (.aclk, .aresetn, .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .port_clk, .addr, .address_strobe_n, .count_advance_n,
        .counter_clear_n, .select_active_low_n, .select_active_high, .rw_n, .oe_n, .latency_select,
        .data_i, .data_o, .data_oe, .standby);
    for (genvar p = 0; p < 2; p++) begin : g
        smp_host_model h (.aclk, .port_clk(port_clk[p]), .addr(addr[p*13+:13]),
            .address_strobe_n(address_strobe_n[p]), .count_advance_n(count_advance_n[p]),
            .counter_clear_n(counter_clear_n[p]), .select_active_low_n(select_active_low_n[p]),
            .select_active_high(select_active_high[p]), .rw_n(rw_n[p]), .oe_n(oe_n[p]),
            .latency_select(latency_select[p]), .data_i(data_i[p*9+:9]));
    end
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk9(input logic [8:0] got, input logic [8:0] exp);
        chk({23'h0, got}, {23'h0, exp});
    endtask
    // Register write, checks the response
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w, done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            done = s_axi_bvalid;
            if (done) chk({30'h0, s_axi_bresp}, {30'h0, er});
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask
    // Register read, checking data and response code
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar, done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            ar = s_axi_arvalid & s_axi_arready;
            done = s_axi_rvalid;
            if (done) chk(s_axi_rdata, ed);
            if (done) chk({30'h0, s_axi_rresp}, {30'h0, er});
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask
    task automatic test_done();
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Watchdog, far past the expected run
    initial begin
        #500_000;
        fails++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        axi_rd(`SMP_REG_CTRL, 32'h0000_0000, `SMP_RESP_OKAY);
        axi_rd(`SMP_REG_STATUS, 32'h0000_0003, `SMP_RESP_OKAY);
        axi_rd(`SMP_REG_CNT0, 32'h0000_0000, `SMP_RESP_OKAY);
        axi_rd(8'h10, 32'h0000_0000, `SMP_RESP_SLVERR);
        axi_wr(8'h10, 32'h0000_0001, `SMP_RESP_SLVERR);
        axi_wr(`SMP_REG_STATUS, 32'h0000_0000, `SMP_RESP_OKAY);
        axi_rd(`SMP_REG_STATUS, 32'h0000_0003, `SMP_RESP_OKAY);
        $display("test registers done");
        // Flow writes and reads; no address from both ports at once
        g[0].h.cyc(1'b0, 13'h0005, 9'h1a5, LOAD);
        g[0].h.cyc(1'b0, 13'h1fff, 9'h05a, LOAD);
        g[0].h.cyc(1'b1, 13'h0005, 9'h000, LOAD);
        chk9(data_o[8:0], 9'h1a5);
        chk9({8'h00, data_oe[0]}, 9'h001);
        g[1].h.cyc(1'b1, 13'h1fff, 9'h000, LOAD);
        chk9(data_o[17:9], 9'h05a);
        $display("test flow access done");
        g[0].h.cyc(1'b1, 13'h1ffe, 9'h000, LOAD);
        axi_rd(`SMP_REG_CNT0, 32'h0000_1ffe, `SMP_RESP_OKAY);
        g[0].h.cyc(1'b1, 13'h0000, 9'h000, ADV);
        axi_rd(`SMP_REG_CNT0, 32'h0000_1fff, `SMP_RESP_OKAY);
        chk9(data_o[8:0], 9'h05a);
        g[0].h.cyc(1'b1, 13'h0000, 9'h000, ADV);
        axi_rd(`SMP_REG_CNT0, 32'h0000_0000, `SMP_RESP_OKAY);
        g[0].h.cyc(1'b1, 13'h0040, 9'h000, HOLD);
        axi_rd(`SMP_REG_CNT0, 32'h0000_0000, `SMP_RESP_OKAY);
        g[0].h.cyc(1'b1, 13'h0022, 9'h000, BOTH);
        axi_rd(`SMP_REG_CNT0, 32'h0000_0022, `SMP_RESP_OKAY);
        g[0].h.cyc(1'b1, 13'h0033, 9'h000, ALL);
        axi_rd(`SMP_REG_CNT0, 32'h0000_0000, `SMP_RESP_OKAY);
        g[0].h.cyc(1'b1, 13'h0000, 9'h000, DADV);
        axi_rd(`SMP_REG_CNT0, 32'h0000_0001, `SMP_RESP_OKAY);
        axi_rd(`SMP_REG_CNT1, 32'h0000_1fff, `SMP_RESP_OKAY);
        g[0].h.cyc(1'b0, 13'h0010, 9'h011, LOAD);
        g[0].h.cyc(1'b0, 13'h0000, 9'h012, ADV);
        g[0].h.cyc(1'b1, 13'h0011, 9'h000, LOAD);
        chk9(data_o[8:0], 9'h012);
        $display("test counter done");
        for (int i = 0; i < 4; i++) begin
            g[0].h.cyc(1'b1, 13'h0000, 9'h000, {3'b111, 2'(i)});
            chk9({8'h00, standby[0]}, {8'h00, i != 1});
            g[1].h.cyc(1'b1, 13'h0000, 9'h000, {3'b111, 2'(i)});
            chk9({7'h00, standby[1], data_oe[1]}, {7'h00, i != 1, i == 1});
        end
        $display("test selects done");
        g[0].h.set_mode(1'b1, 1'b0);
        g[0].h.cyc(1'b1, 13'h0005, 9'h000, LOAD);
        g[0].h.cyc(1'b1, 13'h0011, 9'h000, LOAD);
        chk9(data_o[8:0], 9'h1a5);
        g[0].h.cyc(1'b1, 13'h0005, 9'h000, LOAD);
        chk9(data_o[8:0], 9'h012);
        g[0].h.cyc(1'b1, 13'h0005, 9'h000, DES);
        chk9({7'h00, standby[0], data_oe[0]}, 9'h003);
        g[0].h.cyc(1'b1, 13'h0005, 9'h000, LOAD);
        chk9({8'h00, data_oe[0]}, 9'h000);
        g[0].h.cyc(1'b1, 13'h0005, 9'h000, LOAD);
        chk9({8'h00, data_oe[0]}, 9'h001);
        chk9(data_o[8:0], 9'h1a5);
        $display("test pipelined done");
        g[0].h.set_mode(1'b0, 1'b1);
        g[0].h.cyc(1'b1, 13'h0005, 9'h000, LOAD);
        chk9({8'h00, data_oe[0]}, 9'h000);
        g[0].h.set_mode(1'b0, 1'b0);
        axi_wr(`SMP_REG_CTRL, 32'h0000_0001, `SMP_RESP_OKAY);
        axi_rd(`SMP_REG_CTRL, 32'h0000_0001, `SMP_RESP_OKAY);
        g[0].h.cyc(1'b1, 13'h0005, 9'h000, LOAD);
        chk9({7'h00, standby[0], data_oe[0]}, 9'h002);
        axi_wr(`SMP_REG_CTRL, 32'h0000_0000, `SMP_RESP_OKAY);
        $display("test enable and control done");
        test_done();
    end
endmodule
`default_nettype wire
